// *** include/svio_pkg.sv ***
package svio_pkg;
  localparam logic [5:0] IO_VARYING = 6'h23;
  localparam logic [5:0] IO_VECTOR = 6'h30;
  localparam logic [5:0] IO_SETUP = 6'h31;
  localparam logic [5:0] IO_DMA = 6'h32;
  localparam int ID_LO = 30;
  localparam int NUM_LO = 20;
  localparam int STRIDE_LO = 12;
  localparam int HORIZ_BIT = 11;
  localparam int LANED_BIT = 10;
  localparam int SIZE_LO = 8;
  localparam logic [1:0] SZ_8 = 2'h0;
  localparam logic [1:0] SZ_16 = 2'h1;
  localparam int LANES = 16;
  localparam int MEM_COLS = 16;
  localparam int MEM_ROWS = 64;
  localparam int VEC_W = 512;
  localparam int CLK_MHZ = 50;
  localparam int READ_LAT_INSTR = 3;
  localparam int CYC_PER_INSTR = 1;
  localparam logic [1:0] READ_LAT_CYC = 2'(READ_LAT_INSTR * CYC_PER_INSTR);
  localparam logic [1:0] WR_COMMIT_CYC = 2'h3;
  localparam logic [1:0] QUEUE_DEPTH = 2'h2;

  typedef enum logic [2:0] {
    VS_IDLE = 3'b001,
    VS_DRAIN = 3'b010,
    VS_RUN = 3'b100
  } svio_vstate_t;

  typedef struct packed {
    logic [4:0] left;
    logic [6:0] stride;
    logic horiz;
    logic laned;
    logic [1:0] size;
    logic [7:0] addr;
    logic [1:0] age;
  } svio_blk_t;

  typedef struct packed {
    svio_vstate_t vst;
    logic prog_run;
    logic pend_start;
    logic [5:0] pend_num;
    logic [5:0] run_left;
    logic [5:0] read_left;
    logic coef_rdy;
    logic st_v;
    logic [31:0] st_vp;
    logic [31:0] st_c;
    logic rd_valid;
    logic [VEC_W-1:0] rd_data;
    logic [31:0] coef_acc;
    logic coef_load;
    logic wr_ack;
    svio_blk_t wcfg;
    logic [1:0] wq_cnt;
    logic [1:0] wq_tmr;
    svio_blk_t [1:0] wq_blk;
    logic [1:0][VEC_W-1:0] wq_data;
    logic [1:0] rq_cnt;
    svio_blk_t [1:0] rq;
    logic [31:0] ld_setup;
    logic [31:0] st_setup;
    logic [31:0] ld_addr;
    logic [31:0] st_addr;
    logic ld_busy;
    logic st_busy;
    logic ld_start;
    logic st_start;
  } svio_state_t;
endpackage

// *** logic/svio_fifo.sv ***
`timescale 1ns/1ps
module svio_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [$clog2(DEPTH+1)-1:0] count_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } svio_fifo_state_t;
  svio_fifo_state_t s_r;
  svio_fifo_state_t s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready_out = (s_r.cnt != CW'(DEPTH));
  assign out_valid_out = (s_r.cnt != '0);
  assign out_data_out = mem[s_r.rp];
  assign count_out = s_r.cnt;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[s_r.wp] <= in_data_in;
    end
  end
endmodule // svio_fifo

// *** logic/svio_vary_io_unit.sv ***
`timescale 1ns/1ps
module svio_vary_io_unit #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Core register reads
  input wire logic io_rd_in,
  input wire logic [5:0] io_rd_addr_in,
  input wire logic io_rd_b_in,
  output logic io_rd_valid_out,
  output logic [svio_pkg::VEC_W-1:0] io_rd_data_out,
  output logic [31:0] coef_acc_out,
  output logic coef_acc_load_out,
  // Core register writes
  input wire logic io_wr_in,
  input wire logic [5:0] io_wr_addr_in,
  input wire logic io_wr_b_in,
  input wire logic [svio_pkg::VEC_W-1:0] io_wr_data_in,
  output logic io_wr_ack_out,
  // Program control
  input wire logic frag_start_in,
  input wire logic [5:0] frag_num_vary_in,
  input wire logic prog_end_in,
  // Varying coefficients
  input wire logic coef_valid_in,
  input wire logic [31:0] coef_a_in,
  input wire logic [31:0] coef_b_in,
  input wire logic [31:0] coef_c_in,
  input wire logic [31:0] dx_in,
  input wire logic [31:0] dy_in,
  output logic coef_ready_out,
  // Memory reservation
  input wire logic [6:0] rsv_rows_in,
  // DMA engines
  output logic dma_ld_start_out,
  output logic [31:0] dma_ld_addr_out,
  output logic [31:0] dma_ld_setup_out,
  input wire logic dma_ld_done_in,
  output logic dma_st_start_out,
  output logic [31:0] dma_st_addr_out,
  output logic [31:0] dma_st_setup_out,
  input wire logic dma_st_done_in
);
  localparam int LN = svio_pkg::LANES;
  localparam int CW = $clog2(FIFO_DEPTH+1);
  svio_pkg::svio_state_t s_r;
  svio_pkg::svio_state_t s_nxt;
  logic [31:0] mem [svio_pkg::MEM_ROWS*svio_pkg::MEM_COLS];
  logic [11:0] wpos [LN];
  logic [11:0] rpos [LN];
  logic [LN*4-1:0] wen;
  logic [7:0] wbyte [LN][4];
  logic [svio_pkg::VEC_W-1:0] rvec;
  logic [31:0] rmask;
  logic [2:0] wnb;
  logic commit;
  logic vary_pop;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [63:0] fifo_out;
  logic [CW-1:0] fifo_cnt;
  logic [31:0] w0;
  function automatic logic [11:0] f_pos(input svio_pkg::svio_blk_t b,
                                        input logic [3:0] e);
    logic [5:0] a6;
    logic [1:0] sub;
    logic [3:0] wi;
    logic [1:0] lane;
    logic [5:0] row;
    logic [3:0] col;
    a6 = b.addr[5:0];
    sub = 2'h0;
    wi = e;
    lane = 2'h0;
    if (b.size == svio_pkg::SZ_16) begin
      a6 = b.addr[6:1];
      sub = {1'b0, b.addr[0]};
      if (b.laned) begin
        lane = {sub[0], 1'b0};
      end else begin
        wi = {sub[0], e[3:1]};
        lane = {e[0], 1'b0};
      end
    end else if (b.size == svio_pkg::SZ_8) begin
      a6 = b.addr[7:2];
      sub = b.addr[1:0];
      if (b.laned) begin
        lane = sub;
      end else begin
        wi = {sub, e[3:2]};
        lane = e[1:0];
      end
    end
    if (b.horiz) begin
      row = a6;
      col = wi;
    end else begin
      row = {a6[5:4], 4'h0} + {2'h0, wi};
      col = a6[3:0];
    end
    return {row, col, lane};
  endfunction
  function automatic svio_pkg::svio_blk_t f_blk(input logic [31:0] w);
    svio_pkg::svio_blk_t b;
    b.left = (w[svio_pkg::NUM_LO +: 4] == 4'h0) ? 5'h10 :
             {1'b0, w[svio_pkg::NUM_LO +: 4]};
    b.stride = {(w[svio_pkg::STRIDE_LO +: 6] == 6'h0),
                w[svio_pkg::STRIDE_LO +: 6]};
    b.horiz = w[svio_pkg::HORIZ_BIT];
    b.laned = w[svio_pkg::LANED_BIT];
    b.size = w[svio_pkg::SIZE_LO +: 2];
    b.addr = w[7:0];
    b.age = 2'h0;
    return b;
  endfunction
  assign w0 = io_wr_data_in[31:0];
  assign wnb = (s_r.wq_blk[0].size == svio_pkg::SZ_8) ? 3'h1 :
               (s_r.wq_blk[0].size == svio_pkg::SZ_16) ? 3'h2 : 3'h4;
  assign rmask = (s_r.rq[0].size == svio_pkg::SZ_8) ? 32'h000000ff :
                 (s_r.rq[0].size == svio_pkg::SZ_16) ? 32'h0000ffff :
                 32'hffffffff;
  for (genvar g = 0; g < LN; g++) begin : g_lane
    assign wpos[g] = f_pos(s_r.wq_blk[0], 4'(g));
    assign rpos[g] = f_pos(s_r.rq[0], 4'(g));
    assign rvec[g*32 +: 32] = (mem[rpos[g][11:2]] >>
                               {rpos[g][1:0], 3'h0}) & rmask;
    for (genvar k = 0; k < 4; k++) begin : g_byte
      assign wen[g*4+k] = ({1'b0, wpos[g][11:6]} < rsv_rows_in) &&
                          (2'(k) >= wpos[g][1:0]) &&
                          (3'(k) < {1'b0, wpos[g][1:0]} + wnb);
      assign wbyte[g][k] = 8'(s_r.wq_data[0][g*32 +: 32] >>
                              {3'(k) - {1'b0, wpos[g][1:0]}, 3'h0});
    end
  end
  svio_fifo #(
    .WIDTH(64),
    .DEPTH(FIFO_DEPTH)
  ) u_vary_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .in_valid_in(s_r.st_v),
    .in_ready_out(fifo_in_ready),
    .in_data_in({s_r.st_c, s_r.st_vp}),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(vary_pop),
    .out_data_out(fifo_out),
    .count_out(fifo_cnt)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_valid = 1'b0;
    s_nxt.wr_ack = 1'b0;
    s_nxt.coef_load = 1'b0;
    s_nxt.ld_start = 1'b0;
    s_nxt.st_start = 1'b0;
    commit = 1'b0;
    vary_pop = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (s_r.rq[i].age != svio_pkg::READ_LAT_CYC) begin
        s_nxt.rq[i].age = s_r.rq[i].age + 2'h1;
      end
    end
    if (s_r.wq_cnt != 2'h0) begin
      s_nxt.wq_tmr = s_r.wq_tmr + 2'h1;
      if (s_r.wq_tmr == svio_pkg::WR_COMMIT_CYC - 2'h1) begin
        commit = 1'b1;
        s_nxt.wq_tmr = 2'h0;
        s_nxt.wq_blk[0] = s_r.wq_blk[1];
        s_nxt.wq_data[0] = s_r.wq_data[1];
        s_nxt.wq_cnt = s_r.wq_cnt - 2'h1;
      end
    end
    s_nxt.ld_busy = s_r.ld_busy && !dma_ld_done_in;
    s_nxt.st_busy = s_r.st_busy && !dma_st_done_in;
    s_nxt.st_v = s_r.st_v && !fifo_in_ready;
    if (s_r.coef_rdy && coef_valid_in) begin
      s_nxt.st_v = 1'b1;
      s_nxt.st_vp = coef_a_in * dx_in + coef_b_in * dy_in;
      s_nxt.st_c = coef_c_in;
      s_nxt.run_left = s_r.run_left - 6'h1;
    end
    if (frag_start_in) begin
      s_nxt.pend_start = 1'b1;
      s_nxt.pend_num = frag_num_vary_in;
    end
    s_nxt.prog_run = s_r.prog_run && !prog_end_in;
    unique case (s_r.vst)
      svio_pkg::VS_IDLE: begin
        if (s_r.pend_start && (!s_r.prog_run || prog_end_in)) begin
          s_nxt.vst = svio_pkg::VS_DRAIN;
          s_nxt.pend_start = frag_start_in;
          s_nxt.prog_run = 1'b1;
          s_nxt.run_left = s_r.pend_num;
          s_nxt.read_left = s_r.pend_num;
        end
      end
      svio_pkg::VS_DRAIN: begin
        if (s_r.wq_cnt == 2'h0 && !s_r.ld_busy && !s_r.st_busy) begin
          s_nxt.vst = svio_pkg::VS_RUN;
        end
      end
      svio_pkg::VS_RUN: begin
        if (s_nxt.run_left == 6'h0) begin
          s_nxt.vst = svio_pkg::VS_IDLE;
        end
      end
      default: begin
        s_nxt.vst = svio_pkg::VS_IDLE;
      end
    endcase
    s_nxt.coef_rdy = (s_nxt.vst == svio_pkg::VS_RUN) &&
                     (s_nxt.run_left != 6'h0) &&
                     (int'(fifo_cnt) + 3 <= FIFO_DEPTH);
    if (io_rd_in && !s_r.rd_valid) begin
      case (io_rd_addr_in)
        svio_pkg::IO_VARYING: begin
          if (s_r.read_left == 6'h0) begin
            s_nxt.rd_valid = 1'b1;
            s_nxt.rd_data = '0;
          end else if (fifo_out_valid) begin
            vary_pop = 1'b1;
            s_nxt.rd_valid = 1'b1;
            s_nxt.rd_data = {480'h0, fifo_out[31:0]};
            s_nxt.coef_acc = fifo_out[63:32];
            s_nxt.coef_load = 1'b1;
            s_nxt.read_left = s_r.read_left - 6'h1;
          end
        end
        svio_pkg::IO_VECTOR: begin
          s_nxt.rd_valid = 1'b1;
          s_nxt.rd_data = '0;
          if (s_r.rq_cnt != 2'h0 &&
              s_r.rq[0].age == svio_pkg::READ_LAT_CYC) begin
            s_nxt.rd_data = rvec;
            s_nxt.rq[0].addr = s_r.rq[0].addr +
                               {1'b0, s_r.rq[0].stride};
            s_nxt.rq[0].left = s_r.rq[0].left - 5'h1;
            if (s_r.rq[0].left == 5'h1) begin
              s_nxt.rq[0] = s_nxt.rq[1];
              s_nxt.rq_cnt = s_r.rq_cnt - 2'h1;
            end
          end
        end
        svio_pkg::IO_SETUP: begin
          s_nxt.rd_valid = 1'b1;
          s_nxt.rd_data = {511'h0, io_rd_b_in ? s_r.st_busy : s_r.ld_busy};
        end
        svio_pkg::IO_DMA: begin
          if (!(io_rd_b_in ? s_r.st_busy : s_r.ld_busy)) begin
            s_nxt.rd_valid = 1'b1;
            s_nxt.rd_data = '0;
          end
        end
        default: begin
          s_nxt.rd_valid = 1'b1;
          s_nxt.rd_data = '0;
        end
      endcase
    end
    if (io_wr_in && !s_r.wr_ack) begin
      s_nxt.wr_ack = 1'b1;
      case (io_wr_addr_in)
        svio_pkg::IO_VECTOR: begin
          if (s_nxt.wq_cnt != svio_pkg::QUEUE_DEPTH) begin
            s_nxt.wq_blk[s_nxt.wq_cnt[0]] = s_r.wcfg;
            s_nxt.wq_data[s_nxt.wq_cnt[0]] = io_wr_data_in;
            s_nxt.wq_cnt = s_nxt.wq_cnt + 2'h1;
            s_nxt.wcfg.addr = s_r.wcfg.addr +
                              {1'b0, s_r.wcfg.stride};
          end else begin
            s_nxt.wr_ack = 1'b0;
          end
        end
        svio_pkg::IO_SETUP: begin
          if (w0[31:svio_pkg::ID_LO] != 2'h0) begin
            if (io_wr_b_in) begin
              s_nxt.st_setup = w0;
            end else begin
              s_nxt.ld_setup = w0;
            end
          end else if (io_wr_b_in) begin
            s_nxt.wcfg = f_blk(w0);
          end else if (s_nxt.rq_cnt != svio_pkg::QUEUE_DEPTH) begin
            s_nxt.rq[s_nxt.rq_cnt[0]] = f_blk(w0);
            s_nxt.rq_cnt = s_nxt.rq_cnt + 2'h1;
          end
        end
        svio_pkg::IO_DMA: begin
          if (io_wr_b_in && !s_r.st_busy) begin
            s_nxt.st_busy = 1'b1;
            s_nxt.st_start = 1'b1;
            s_nxt.st_addr = w0;
          end else if (!io_wr_b_in && !s_r.ld_busy) begin
            s_nxt.ld_busy = 1'b1;
            s_nxt.ld_start = 1'b1;
            s_nxt.ld_addr = w0;
          end
        end
        default: begin
          s_nxt.wr_ack = 1'b1;
        end
      endcase
    end
    if (prog_end_in) begin
      s_nxt.rq_cnt = 2'h0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
      s_r.vst <= svio_pkg::VS_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    for (int e = 0; e < LN; e++) begin
      for (int b = 0; b < 4; b++) begin
        if (commit && wen[e*4+b]) begin
          mem[wpos[e][11:2]][b*8 +: 8] <= wbyte[e][b];
        end
      end
    end
  end

  assign io_rd_valid_out = s_r.rd_valid;
  assign io_rd_data_out = s_r.rd_data;
  assign coef_acc_out = s_r.coef_acc;
  assign coef_acc_load_out = s_r.coef_load;
  assign io_wr_ack_out = s_r.wr_ack;
  assign coef_ready_out = s_r.coef_rdy;
  assign dma_ld_start_out = s_r.ld_start;
  assign dma_ld_addr_out = s_r.ld_addr;
  assign dma_ld_setup_out = s_r.ld_setup;
  assign dma_st_start_out = s_r.st_start;
  assign dma_st_addr_out = s_r.st_addr;
  assign dma_st_setup_out = s_r.st_setup;
endmodule // svio_vary_io_unit

// *** verif/svio_core_model.sv ***
`timescale 1ns/1ps
// Shader core model: holds each request until its answer is sampled or 40 cycles pass.
module svio_core_model (
  // Clock
  input wire logic clk_sys_in,
  // Register reads
  output logic io_rd_out,
  output logic [5:0] io_rd_addr_out,
  output logic io_rd_b_out,
  input wire logic io_rd_valid_in,
  // Register writes
  output logic io_wr_out,
  output logic [5:0] io_wr_addr_out,
  output logic io_wr_b_out,
  output logic [svio_pkg::VEC_W-1:0] io_wr_data_out,
  input wire logic io_wr_ack_in
);
  realtime t_rd = -1.0;
  realtime t_wr = -1.0;
  initial begin
    io_rd_out = 1'b0;
    io_rd_addr_out = 6'h0;
    io_rd_b_out = 1'b0;
    io_wr_out = 1'b0;
    io_wr_addr_out = 6'h0;
    io_wr_b_out = 1'b0;
    io_wr_data_out = '0;
  end
  // Called at a falling edge; the released address shows its inverted value.
  task automatic rd(input logic [5:0] a, input logic b, output logic ok);
    if ($realtime == t_rd) begin
      @(negedge clk_sys_in);
    end
    io_rd_addr_out = a;
    io_rd_b_out = b;
    io_rd_out = 1'b1;
    ok = 1'b0;
    for (int n = 0; n < 40 && ok !== 1'b1; n++) begin
      @(posedge clk_sys_in);
      ok = io_rd_valid_in;
    end
    @(negedge clk_sys_in);
    io_rd_out = 1'b0;
    io_rd_addr_out = ~a;
    t_rd = $realtime;
  endtask
  // Set-up and address values travel in element 0.
  task automatic wr(input logic [5:0] a, input logic b,
                    input logic [svio_pkg::VEC_W-1:0] d, output logic ok);
    if ($realtime == t_wr) begin
      @(negedge clk_sys_in);
    end
    io_wr_addr_out = a;
    io_wr_b_out = b;
    io_wr_data_out = d;
    io_wr_out = 1'b1;
    ok = 1'b0;
    for (int n = 0; n < 40 && ok !== 1'b1; n++) begin
      @(posedge clk_sys_in);
      ok = io_wr_ack_in;
    end
    @(negedge clk_sys_in);
    io_wr_out = 1'b0;
    io_wr_data_out = ~d;
    t_wr = $realtime;
  endtask
endmodule // svio_core_model

// *** verif/svio_vary_io_sva.sv ***
`timescale 1ns/1ps
module svio_vary_io_sva #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Core side
  input wire logic io_rd_in,
  input wire logic [5:0] io_rd_addr_in,
  input wire logic io_rd_b_in,
  input wire logic io_rd_valid_out,
  input wire logic coef_acc_load_out,
  input wire logic io_wr_in,
  input wire logic [5:0] io_wr_addr_in,
  input wire logic [svio_pkg::VEC_W-1:0] io_wr_data_in,
  input wire logic io_wr_ack_out,
  // DMA side
  input wire logic dma_ld_start_out,
  input wire logic [31:0] dma_ld_addr_out,
  input wire logic dma_ld_done_in,
  input wire logic dma_st_start_out,
  input wire logic dma_st_done_in
);
  logic ld_busy_r;
  logic st_busy_r;
  logic rd_take;
  logic wr_take;
  assign rd_take = io_rd_in && !io_rd_valid_out;
  assign wr_take = io_wr_in && !io_wr_ack_out;
  // Tracks each engine from launch until its done pulse.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ld_busy_r <= 1'b0;
      st_busy_r <= 1'b0;
    end else begin
      ld_busy_r <= dma_ld_start_out || (ld_busy_r && !dma_ld_done_in);
      st_busy_r <= dma_st_start_out || (st_busy_r && !dma_st_done_in);
    end
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  a_rd_answer_pulse: assert property (
    io_rd_valid_out |=> !io_rd_valid_out)
    else $error("read answer stood over one cycle");
  a_coef_load_with: assert property (
    coef_acc_load_out |-> io_rd_valid_out)
    else $error("accumulator load without read answer");
  a_vector_rd_prompt: assert property (
    rd_take && io_rd_addr_in == svio_pkg::IO_VECTOR |=> io_rd_valid_out)
    else $error("vector read not answered next cycle");
  a_busy_rd_prompt: assert property (
    rd_take && io_rd_addr_in == svio_pkg::IO_SETUP |=> io_rd_valid_out)
    else $error("busy read not answered next cycle");
  a_wr_ack_prompt: assert property (
    wr_take && io_wr_addr_in != svio_pkg::IO_VECTOR |=> io_wr_ack_out)
    else $error("write not acknowledged next cycle");
  a_ld_start_free: assert property (
    dma_ld_start_out |-> io_wr_ack_out && !ld_busy_r)
    else $error("load launched while busy or unacked");
  a_st_start_free: assert property (
    dma_st_start_out |-> io_wr_ack_out && !st_busy_r)
    else $error("store launched while busy or unacked");
  a_ld_addr_elem: assert property (
    dma_ld_start_out |-> dma_ld_addr_out == $past(io_wr_data_in[31:0]))
    else $error("load address not element zero");
  a_ld_wait_stall: assert property (
    rd_take && io_rd_addr_in == svio_pkg::IO_DMA && !io_rd_b_in &&
    ld_busy_r && !dma_ld_done_in |=> !io_rd_valid_out)
    else $error("load wait answered while busy");
  c_vary_read: cover property (coef_acc_load_out);
  c_ld_start: cover property (dma_ld_start_out);
  c_st_start: cover property (dma_st_start_out);
endmodule // svio_vary_io_sva
bind svio_vary_io_unit svio_vary_io_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (
  .clk_sys_in, .rst_in, .io_rd_in, .io_rd_addr_in, .io_rd_b_in,
  .io_rd_valid_out, .coef_acc_load_out, .io_wr_in, .io_wr_addr_in,
  .io_wr_data_in, .io_wr_ack_out, .dma_ld_start_out, .dma_ld_addr_out,
  .dma_ld_done_in, .dma_st_start_out, .dma_st_done_in);

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      err_total++; \
      $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module testbench;
  typedef struct {
    logic [5:0] a;
    logic b;
    logic [31:0] q;
  } svio_row_t;
  logic clk_sys_in, rst_in, io_rd_in, io_rd_b_in, io_rd_valid_out;
  logic io_wr_in, io_wr_b_in, io_wr_ack_out, coef_acc_load_out, ok;
  logic frag_start_in, prog_end_in, coef_valid_in, coef_ready_out;
  logic dma_ld_start_out, dma_ld_done_in, dma_st_start_out, dma_st_done_in;
  logic [5:0] io_rd_addr_in, io_wr_addr_in, frag_num_vary_in;
  logic [6:0] rsv_rows_in;
  logic [svio_pkg::VEC_W-1:0] io_rd_data_out, io_wr_data_in;
  logic [31:0] coef_acc_out, coef_a_in, coef_b_in, coef_c_in, dx_in, dy_in;
  logic [31:0] dma_ld_addr_out, dma_ld_setup_out, dma_st_addr_out;
  logic [31:0] dma_st_setup_out;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int n_ld = 0;
  int n_st = 0;
  int c0;
  svio_row_t rows [7] = '{'{6'h31, 1'b0, 32'h0}, '{6'h31, 1'b1, 32'h0},
    '{6'h32, 1'b0, 32'h0}, '{6'h32, 1'b1, 32'h0}, '{6'h30, 1'b0, 32'h0},
    '{6'h30, 1'b1, 32'h0}, '{6'h10, 1'b0, 32'h0}};
  svio_core_model u_core (.clk_sys_in, .io_rd_out(io_rd_in),
    .io_rd_addr_out(io_rd_addr_in), .io_rd_b_out(io_rd_b_in),
    .io_rd_valid_in(io_rd_valid_out), .io_wr_out(io_wr_in),
    .io_wr_addr_out(io_wr_addr_in), .io_wr_b_out(io_wr_b_in),
    .io_wr_data_out(io_wr_data_in), .io_wr_ack_in(io_wr_ack_out));
  svio_vary_io_unit #(.FIFO_DEPTH(8)) u_dut (.clk_sys_in, .rst_in,
    .io_rd_in, .io_rd_addr_in, .io_rd_b_in, .io_rd_valid_out,
    .io_rd_data_out, .coef_acc_out, .coef_acc_load_out, .io_wr_in,
    .io_wr_addr_in, .io_wr_b_in, .io_wr_data_in, .io_wr_ack_out,
    .frag_start_in, .frag_num_vary_in, .prog_end_in, .coef_valid_in,
    .coef_a_in, .coef_b_in, .coef_c_in, .dx_in, .dy_in, .coef_ready_out,
    .rsv_rows_in, .dma_ld_start_out, .dma_ld_addr_out, .dma_ld_setup_out,
    .dma_ld_done_in, .dma_st_start_out, .dma_st_addr_out,
    .dma_st_setup_out, .dma_st_done_in);
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    n_ld += int'(dma_ld_start_out === 1'b1);
    n_st += int'(dma_st_start_out === 1'b1);
  end
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic hang(input logic k);
    if (k !== 1'b1) begin
      err_total++;
      $display("Error handshake expected 1 seen %0b", k);
      wrap_up();
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic b);
    u_core.rd(a, b, ok);
    hang(ok);
  endtask
  task automatic wr(input logic [5:0] a, input logic b,
                    input logic [svio_pkg::VEC_W-1:0] d);
    u_core.wr(a, b, d, ok);
    hang(ok);
  endtask
  // Holds valid up between varyings; the caller lowers it.
  task automatic feed(input logic [31:0] a, input logic [31:0] c);
    coef_a_in = a;
    coef_c_in = c;
    coef_valid_in = 1'b1;
    ok = 1'b0;
    for (int n = 0; n < 60 && ok !== 1'b1; n++) begin
      @(posedge clk_sys_in);
      ok = coef_ready_out;
    end
    @(negedge clk_sys_in);
    hang(ok);
  endtask
  task automatic pulse(input logic is_end, input logic [5:0] num);
    frag_num_vary_in = num;
    prog_end_in = is_end;
    frag_start_in = !is_end;
    @(negedge clk_sys_in);
    prog_end_in = 1'b0;
    frag_start_in = 1'b0;
  endtask
  initial begin
    rst_in = 1'b1;
    {frag_start_in, prog_end_in, coef_valid_in} = 3'h0;
    {dma_ld_done_in, dma_st_done_in} = 2'h0;
    frag_num_vary_in = 6'h0;
    {coef_a_in, coef_c_in} = 64'h0;
    coef_b_in = 32'h2;
    dx_in = 32'hfffffffd;
    dy_in = 32'h5;
    rsv_rows_in = 7'h40;
    repeat (8) @(negedge clk_sys_in);
    `CHK("reset", 2'h0, {dma_ld_start_out, dma_st_start_out});
    rst_in = 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].a, rows[i].b);
      `CHK("idle port", rows[i].q, io_rd_data_out[31:0]);
    end
    // Nine varyings overfill the FIFO; the ninth goes in after three reads.
    pulse(1'b0, 6'h09);
    for (int i = 0; i < 8; i++) begin
      feed(32'(i), 32'(i + 16));
    end
    coef_valid_in = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    `CHK("fifo full", 1'b0, coef_ready_out);
    for (int i = 0; i < 9; i++) begin
      rd(svio_pkg::IO_VARYING, i[0]);
      `CHK("varying", {480'h0, 32'(10 - 3 * i)}, io_rd_data_out);
      `CHK("coef", 32'(i + 16), coef_acc_out);
      if (i == 2) begin
        feed(32'h8, 32'h18);
        coef_valid_in = 1'b0;
      end
    end
    rd(svio_pkg::IO_VARYING, 1'b0);
    pulse(1'b1, 6'h0);
    // Three vectors from row 63 wrap to rows 0 and 1.
    wr(svio_pkg::IO_SETUP, 1'b1, 512'h1a3f);
    for (int i = 0; i < 3; i++) begin
      wr(svio_pkg::IO_VECTOR, 1'b0, {16{32'(i) ^ 32'h5a00_c300}});
    end
    repeat (12) @(negedge clk_sys_in);
    wr(svio_pkg::IO_SETUP, 1'b0, 512'h301a3f);
    rd(svio_pkg::IO_VECTOR, 1'b0);
    `CHK("early read", 512'h0, io_rd_data_out);
    repeat (3) @(negedge clk_sys_in);
    for (int i = 0; i < 4; i++) begin
      rd(svio_pkg::IO_VECTOR, i[0]);
      `CHK("vector", (i < 3) ? {16{32'(i) ^ 32'h5a00_c300}} : 512'h0,
           io_rd_data_out);
    end
    // A third queued set-up is dropped, then program end cancels reads.
    for (int i = 0; i < 3; i++) begin
      wr(svio_pkg::IO_SETUP, 1'b0, 512'h101a3f);
    end
    repeat (4) @(negedge clk_sys_in);
    for (int i = 0; i < 3; i++) begin
      rd(svio_pkg::IO_VECTOR, 1'b0);
      `CHK("queue", (i < 2) ? {16{32'h5a00_c300}} : 512'h0,
           io_rd_data_out);
    end
    wr(svio_pkg::IO_SETUP, 1'b0, 512'h101a3f);
    pulse(1'b1, 6'h0);
    repeat (4) @(negedge clk_sys_in);
    rd(svio_pkg::IO_VECTOR, 1'b0);
    `CHK("cancel", 512'h0, io_rd_data_out);
    // Row 1 lies outside a one-row window: the write is masked, the read
    // still returns, and an 8-bit laned read of row 63 picks byte 1.
    rsv_rows_in = 7'h1;
    wr(svio_pkg::IO_SETUP, 1'b1, 512'h1a01);
    wr(svio_pkg::IO_VECTOR, 1'b0, '1);
    repeat (6) @(negedge clk_sys_in);
    wr(svio_pkg::IO_SETUP, 1'b0, 512'h101a01);
    wr(svio_pkg::IO_SETUP, 1'b0, 512'h101cfd);
    repeat (4) @(negedge clk_sys_in);
    rd(svio_pkg::IO_VECTOR, 1'b0);
    `CHK("masked", {16{32'h5a00_c302}}, io_rd_data_out);
    rd(svio_pkg::IO_VECTOR, 1'b1);
    `CHK("laned byte", {16{32'hc3}}, io_rd_data_out);
    // Launch both engines; a launch while busy is dropped.
    for (int i = 0; i < 2; i++) begin
      wr(svio_pkg::IO_SETUP, i[0], 512'h4000_0005);
      wr(svio_pkg::IO_DMA, i[0], 512'(32'h1000 + i));
      wr(svio_pkg::IO_DMA, i[0], 512'h2000);
      rd(svio_pkg::IO_SETUP, i[0]);
      `CHK("busy", 1'b1, io_rd_data_out[0]);
    end
    `CHK("ld addr", 32'h1000, dma_ld_addr_out);
    `CHK("st addr", 32'h1001, dma_st_addr_out);
    `CHK("ld setup", 32'h4000_0005, dma_ld_setup_out);
    `CHK("st setup", 32'h4000_0005, dma_st_setup_out);
    `CHK("launches", 2, n_ld + n_st);
    pulse(1'b0, 6'h01);
    repeat (4) @(negedge clk_sys_in);
    `CHK("held off", 1'b0, coef_ready_out);
    c0 = cyc;
    fork
      rd(svio_pkg::IO_DMA, 1'b0);
      begin
        repeat (6) @(negedge clk_sys_in);
        dma_ld_done_in = 1'b1;
        dma_st_done_in = 1'b1;
        @(negedge clk_sys_in);
        {dma_ld_done_in, dma_st_done_in} = 2'h0;
      end
    join
    `CHK("wait stall", 1'b1, cyc - c0 >= 6);
    rd(svio_pkg::IO_SETUP, 1'b1);
    `CHK("idle", 1'b0, io_rd_data_out[0]);
    feed(32'h1, 32'h7);
    coef_valid_in = 1'b0;
    rd(svio_pkg::IO_VARYING, 1'b1);
    `CHK("late varying", 512'h7, io_rd_data_out);
    pulse(1'b1, 6'h0);
    wrap_up();
  end
endmodule // testbench
